/* sim/cdm_regs_chk.sv */
`timescale 1ns/10ps
module cdm_regs_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        left_input_path_enable,
  input wire logic        ref_tick,
  input wire logic        left_boost_mixer_on,
  input wire logic        left_input_amp_on,
  input wire logic        left_boost_mixer_mute,
  input wire logic        right_boost_mixer_mute,
  input wire logic [2:0]  left_second_input_gain,
  input wire logic [2:0]  left_pga_to_mixer_gain,
  input wire logic [2:0]  left_third_input_gain,
  input wire logic [2:0]  left_source_connect,
  input wire logic [2:0]  right_source_connect,
  input wire logic [2:0]  boost_mixer_bias_scale,
  input wire logic [2:0]  input_amp_bias_scale,
  input wire logic        bias_code_reserved
);
  import cdm_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic wr_mute;
  logic wr_lg;
  logic wr_sel;
  logic wr_bias;
  assign wr_mute = reg_wr && reg_addr == ADDR_MUTE_ENABLE;
  assign wr_lg   = reg_wr && reg_addr == ADDR_LEFT_GAINS;
  assign wr_sel  = reg_wr && reg_addr == ADDR_SOURCE_SELECT;
  assign wr_bias = reg_wr && reg_addr == ADDR_BIAS_SCALING;
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside its slot");
  a_mute_write: assert property (wr_mute |=>
    {left_boost_mixer_mute, right_boost_mixer_mute} == $past(reg_wdata[3:2]))
    else $error("mute bits not taken from write");
  a_mute_hold: assert property (!wr_mute |=>
    $stable(left_boost_mixer_mute) && $stable(right_boost_mixer_mute))
    else $error("mute changed without a write");
  a_gain_write: assert property (wr_lg |=> {left_second_input_gain,
    left_pga_to_mixer_gain, left_third_input_gain} == $past(reg_wdata[8:0]))
    else $error("left gains not taken from write");
  a_select_write: assert property (wr_sel |=>
    {left_source_connect, right_source_connect} == $past(reg_wdata[5:0]))
    else $error("source selects not taken from write");
  a_bias_write: assert property (wr_bias |=>
    {boost_mixer_bias_scale, input_amp_bias_scale} == $past(reg_wdata[5:0]))
    else $error("bias codes not taken from write");
  a_bias_flag: assert property (bias_code_reserved ==
    (!(boost_mixer_bias_scale inside {3'h0, 3'h3, 3'h4}) ||
     !(input_amp_bias_scale inside {3'h0, 3'h4})))
    else $error("reserved bias flag wrong");
  a_path_enable: assert property (left_input_path_enable |->
    left_boost_mixer_on && left_input_amp_on)
    else $error("path enable did not turn on mixer and amp");
  a_ref_pulse: assert property (ref_tick |=> !ref_tick)
    else $error("reference tick longer than one cycle");
endmodule : cdm_regs_chk

/* sim/cdm_regs_tb.sv */
`timescale 1ns/10ps
module cdm_regs_tb;
  import cdm_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        left_input_path_enable = 1'b0;
  logic        right_input_path_enable = 1'b0;
  logic [15:0] reg_rdata;
  logic        ref_tick, debounce_tick, timeout_tick, gpio_output_clock, bias_code_reserved;
  logic        left_boost_mixer_on, right_boost_mixer_on, left_input_amp_on, right_input_amp_on;
  logic        left_boost_mixer_mute, right_boost_mixer_mute;
  logic [2:0]  left_second_input_gain, left_pga_to_mixer_gain, left_third_input_gain;
  logic [2:0]  right_second_input_gain, right_pga_to_mixer_gain, right_third_input_gain;
  logic [2:0]  left_source_connect, right_source_connect;
  logic [2:0]  boost_mixer_bias_scale, input_amp_bias_scale;
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;
  logic [15:0] v;
  logic [15:0] f;
  logic [7:0]  ad [7] = '{ADDR_CLOCK_RATE_DIVIDERS, ADDR_MUTE_ENABLE, ADDR_LEFT_GAINS,
                          ADDR_RIGHT_GAINS, ADDR_SOURCE_SELECT, ADDR_BIAS_SCALING, 8'h24};
  logic [15:0] rst_e [7] = '{16'h005e, 16'h0000, 16'h0145, 16'h0145, 16'h0009, 16'h0004, 16'h0000};
  logic [15:0] one_e [7] = '{16'hff80, 16'h000f, 16'h01ff, 16'h01ff, 16'h003f, 16'h003f, 16'h0000};
  int          gdiv [8] = '{1, 2, 3, 4, 6, 8, 12, 16};
  localparam int REF_PERIOD = int'(REF_DIV_TARGET) + 1;

  cdm_regs dut_u (.*);

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      $display("Error at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clk_sys);
  endtask : rd

  function automatic logic sg(input int k);
    case (k)
      0: return ref_tick;
      1: return debounce_tick;
      2: return timeout_tick;
      default: return gpio_output_clock;
    endcase
  endfunction : sg

  // First interval after a divider change is skipped, it may still run on the old count
  task automatic per(input int k, input int exp, input string msg);
    int   n;
    int   t;
    logic p;
    logic c;
    n = 0;
    t = 0;
    p = 1'b1;
    while (t < 3) begin
      @(posedge clk_sys);
      #1;
      c = sg(k);
      n++;
      if (c && !p) begin
        t++;
        if (t < 3) n = 0;
      end
      p = c;
    end
    @(posedge clk_sys);
    chk(16'(n), 16'(exp), msg);
  endtask : per

  task automatic give_verdict();
    $display("Checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (5) @(posedge clk_sys);
    // Read at the first edge after release, so the divider reset code is seen
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ad[i], v);
      chk(v, rst_e[i], "reset value");
    end
    rd(ADDR_CLOCK_RATE_DIVIDERS, f);
    chk(f, {9'h000, REF_DIV_TARGET, 1'b0}, "divider target");
    for (int i = 0; i < 7; i++) wr(ad[i], 16'hffff);
    for (int i = 0; i < 7; i++) begin
      rd(ad[i], v);
      chk(v & (i == 0 ? 16'hff81 : 16'hffff), one_e[i], "all ones");
    end
    rd(ADDR_CLOCK_RATE_DIVIDERS, v);
    chk(v & 16'h007e, f & 16'h007e, "divider field write");
    $display("Test registers done");
    wr(ADDR_MUTE_ENABLE, 16'h0006);
    chk({10'h0, left_boost_mixer_mute, right_boost_mixer_mute, left_boost_mixer_on,
         right_boost_mixer_on, left_input_amp_on, right_input_amp_on}, 16'h0018, "mixer");
    left_input_path_enable <= 1'b1;
    wr(ADDR_MUTE_ENABLE, 16'h0009);
    chk({10'h0, left_boost_mixer_mute, right_boost_mixer_mute, left_boost_mixer_on,
         right_boost_mixer_on, left_input_amp_on, right_input_amp_on}, 16'h002e, "path");
    left_input_path_enable  <= 1'b0;
    right_input_path_enable <= 1'b1;
    wr(ADDR_MUTE_ENABLE, 16'h0000);
    chk({10'h0, left_boost_mixer_mute, right_boost_mixer_mute, left_boost_mixer_on,
         right_boost_mixer_on, left_input_amp_on, right_input_amp_on}, 16'h0005, "rpath");
    wr(ADDR_LEFT_GAINS, 16'h01d1);
    wr(ADDR_RIGHT_GAINS, 16'h00ac);
    chk({7'h0, left_second_input_gain, left_pga_to_mixer_gain, left_third_input_gain},
        16'h01d1, "left gains");
    chk({7'h0, right_second_input_gain, right_pga_to_mixer_gain, right_third_input_gain},
        16'h00ac, "right gains");
    wr(ADDR_SOURCE_SELECT, 16'h0024);
    chk({10'h0, left_source_connect, right_source_connect}, 16'h0024, "sources");
    $display("Test mixer fields done");
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_BIAS_SCALING, 16'(i * 9));
      chk({10'h0, boost_mixer_bias_scale, input_amp_bias_scale}, 16'(i * 9), "bias");
      chk({15'h0, bias_code_reserved},
          {15'h0, !(i inside {0, 3, 4}) || !(i inside {0, 4})}, "reserved flag");
    end
    wr(ADDR_BIAS_SCALING, BIAS_RESET);
    chk({15'h0, bias_code_reserved}, 16'h0000, "bias restored");
    $display("Test bias done");
    wr(ADDR_CLOCK_RATE_DIVIDERS, 16'h0000);
    per(0, REF_PERIOD, "reference tick");
    per(1, 256 * REF_PERIOD, "debounce tick");
    per(2, 256 * REF_PERIOD, "timeout tick");
    wr(ADDR_CLOCK_RATE_DIVIDERS, 16'h0080);
    per(2, 512 * REF_PERIOD, "timeout code 1");
    wr(ADDR_CLOCK_RATE_DIVIDERS, 16'h2000);
    per(1, 2048 * REF_PERIOD, "debounce code 1");
    // Code 000 of the gpio divider has two meanings, so it is left out
    for (int c = 1; c < 8; c++) begin
      wr(ADDR_CLOCK_RATE_DIVIDERS, 16'(c) << 10);
      per(3, gdiv[c], "gpio clock");
    end
    $display("Test clock dividers done");
    give_verdict();
  end
endmodule : cdm_regs_tb

bind cdm_regs cdm_regs_chk chk_u (.*);

/* verilog/cdm_pkg.sv */
package cdm_pkg;
  localparam logic [7:0]  ADDR_CLOCK_RATE_DIVIDERS = 8'h1e;
  localparam logic [7:0]  ADDR_MUTE_ENABLE         = 8'h1f;
  localparam logic [7:0]  ADDR_LEFT_GAINS          = 8'h20;
  localparam logic [7:0]  ADDR_RIGHT_GAINS         = 8'h21;
  localparam logic [7:0]  ADDR_SOURCE_SELECT       = 8'h22;
  localparam logic [7:0]  ADDR_BIAS_SCALING        = 8'h23;
  localparam int DBT_LSB = 13;
  localparam int OPC_LSB = 10;
  localparam int TOT_LSB = 7;
  localparam int REF_LSB = 1;
  localparam int LEFT_MUTE_BIT  = 3;
  localparam int RIGHT_MUTE_BIT = 2;
  localparam int LEFT_ENA_BIT   = 1;
  localparam int RIGHT_ENA_BIT  = 0;
  localparam int SECOND_LSB = 6;
  localparam int PGA_LSB    = 3;
  localparam int THIRD_LSB  = 0;
  localparam int MIX_BIAS_LSB = 3;
  localparam int AMP_BIAS_LSB = 0;
  localparam logic [15:0] CLOCK_RATE_WMASK = 16'hff80;
  localparam logic [15:0] MUTE_ENABLE_MASK = 16'h000f;
  localparam logic [15:0] GAINS_MASK       = 16'h01ff;
  localparam logic [15:0] SELECT_MASK      = 16'h003f;
  localparam logic [15:0] BIAS_MASK        = 16'h003f;
  localparam logic [15:0] CLOCK_RATE_RESET  = 16'h0000;
  localparam logic [15:0] MUTE_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] GAINS_RESET       = 16'h0145;
  localparam logic [15:0] SELECT_RESET      = 16'h0009;
  localparam logic [15:0] BIAS_RESET        = 16'h0004;
  localparam logic [5:0]  REF_DIV_RESET     = 6'h2f;
  localparam int SYS_CLK_HZ = 100000000;
  localparam int REF_HZ     = 256000;
  localparam logic [5:0] REF_DIV_TARGET = 6'((SYS_CLK_HZ + REF_HZ - 1) / REF_HZ - 1);
  localparam logic [2:0] BIAS_X2_0  = 3'h0;
  localparam logic [2:0] BIAS_X1_0  = 3'h3;
  localparam logic [2:0] BIAS_X0_67 = 3'h4;
endpackage : cdm_pkg

/* verilog/cdm_regs.sv */
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module cdm_regs (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        left_input_path_enable,
  input  wire logic        right_input_path_enable,
  output logic             ref_tick,
  output logic             debounce_tick,
  output logic             timeout_tick,
  output logic             gpio_output_clock,
  output logic             left_boost_mixer_on,
  output logic             right_boost_mixer_on,
  output logic             left_input_amp_on,
  output logic             right_input_amp_on,
  output logic             left_boost_mixer_mute,
  output logic             right_boost_mixer_mute,
  output logic      [2:0]  left_second_input_gain,
  output logic      [2:0]  left_pga_to_mixer_gain,
  output logic      [2:0]  left_third_input_gain,
  output logic      [2:0]  right_second_input_gain,
  output logic      [2:0]  right_pga_to_mixer_gain,
  output logic      [2:0]  right_third_input_gain,
  output logic      [2:0]  left_source_connect,
  output logic      [2:0]  right_source_connect,
  output logic      [2:0]  boost_mixer_bias_scale,
  output logic      [2:0]  input_amp_bias_scale,
  output logic             bias_code_reserved
);
  import cdm_pkg::*;

  logic [15:0] clock_rate_dividers;
  logic [15:0] input_mixer_mute_enable;
  logic [15:0] left_mixer_gains;
  logic [15:0] right_mixer_gains;
  logic [15:0] mixer_source_select;
  logic [15:0] input_bias_scaling;
  logic [15:0] next_clock_rate_dividers;
  logic [15:0] next_input_mixer_mute_enable;
  logic [15:0] next_left_mixer_gains;
  logic [15:0] next_right_mixer_gains;
  logic [15:0] next_mixer_source_select;
  logic [15:0] next_input_bias_scaling;
  logic [15:0] next_reg_rdata;

  // Hardware-computed reference divider and its counter
  logic [5:0] low_rate_reference_divider;
  logic [5:0] next_low_rate_reference_divider;
  logic [5:0] ref_cnt;
  logic [5:0] next_ref_cnt;
  logic       next_ref_tick;

  // GPIO output clock divider state
  logic [3:0] opc_cnt;
  logic [3:0] next_opc_cnt;
  logic       next_gpio_output_clock;
  logic [3:0] opc_div;
  logic [2:0] opc_code;

  logic [2:0]  dbt_code;
  logic [2:0]  tot_code;
  logic [17:0] dbt_div;
  logic [17:0] tot_div;

  // Register write path
  always_comb begin
    next_clock_rate_dividers     = clock_rate_dividers;
    next_input_mixer_mute_enable = input_mixer_mute_enable;
    next_left_mixer_gains        = left_mixer_gains;
    next_right_mixer_gains       = right_mixer_gains;
    next_mixer_source_select     = mixer_source_select;
    next_input_bias_scaling      = input_bias_scaling;
    if (reg_wr) begin
      // Reference divider bits are not in the write mask
      if (reg_addr == ADDR_CLOCK_RATE_DIVIDERS) begin
        next_clock_rate_dividers = reg_wdata & CLOCK_RATE_WMASK;
      end else if (reg_addr == ADDR_MUTE_ENABLE) begin
        next_input_mixer_mute_enable = reg_wdata & MUTE_ENABLE_MASK;
      end else if (reg_addr == ADDR_LEFT_GAINS) begin
        next_left_mixer_gains = reg_wdata & GAINS_MASK;
      end else if (reg_addr == ADDR_RIGHT_GAINS) begin
        next_right_mixer_gains = reg_wdata & GAINS_MASK;
      end else if (reg_addr == ADDR_SOURCE_SELECT) begin
        next_mixer_source_select = reg_wdata & SELECT_MASK;
      end else if (reg_addr == ADDR_BIAS_SCALING) begin
        next_input_bias_scaling = reg_wdata & BIAS_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clock_rate_dividers     <= CLOCK_RATE_RESET;
      input_mixer_mute_enable <= MUTE_ENABLE_RESET;
      left_mixer_gains        <= GAINS_RESET;
      right_mixer_gains       <= GAINS_RESET;
      mixer_source_select     <= SELECT_RESET;
      input_bias_scaling      <= BIAS_RESET;
    end else begin
      clock_rate_dividers     <= next_clock_rate_dividers;
      input_mixer_mute_enable <= next_input_mixer_mute_enable;
      left_mixer_gains        <= next_left_mixer_gains;
      right_mixer_gains       <= next_right_mixer_gains;
      mixer_source_select     <= next_mixer_source_select;
      input_bias_scaling      <= next_input_bias_scaling;
    end
  end

  // Read path; unmapped addresses return zero
  always_comb begin
    next_reg_rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == ADDR_CLOCK_RATE_DIVIDERS) begin
        next_reg_rdata = clock_rate_dividers
                       | {9'h000, low_rate_reference_divider, 1'b0};
      end else if (reg_addr == ADDR_MUTE_ENABLE) begin
        next_reg_rdata = input_mixer_mute_enable;
      end else if (reg_addr == ADDR_LEFT_GAINS) begin
        next_reg_rdata = left_mixer_gains;
      end else if (reg_addr == ADDR_RIGHT_GAINS) begin
        next_reg_rdata = right_mixer_gains;
      end else if (reg_addr == ADDR_SOURCE_SELECT) begin
        next_reg_rdata = mixer_source_select;
      end else if (reg_addr == ADDR_BIAS_SCALING) begin
        next_reg_rdata = input_bias_scaling;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Reference divider: reset code for one cycle, then the computed target.
  // Limitation: at 100MHz the ideal count does not fit six bits and wraps.
  always_comb begin
    next_low_rate_reference_divider = REF_DIV_TARGET;
    next_ref_tick = 1'b0;
    if (ref_cnt >= low_rate_reference_divider) begin
      next_ref_cnt  = 6'h00;
      next_ref_tick = 1'b1;
    end else begin
      next_ref_cnt = ref_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      low_rate_reference_divider <= REF_DIV_RESET;
      ref_cnt                    <= 6'h00;
      ref_tick                   <= 1'b0;
    end else begin
      low_rate_reference_divider <= next_low_rate_reference_divider;
      ref_cnt                    <= next_ref_cnt;
      ref_tick                   <= next_ref_tick;
    end
  end

  assign dbt_code = clock_rate_dividers[DBT_LSB +: 3];
  assign tot_code = clock_rate_dividers[TOT_LSB +: 3];
  assign opc_code = clock_rate_dividers[OPC_LSB +: 3];

  // Code 110 keeps the printed 64536, not the power of two
  always_comb begin
    case (dbt_code)
      3'h0:    dbt_div = 18'd256;
      3'h1:    dbt_div = 18'd2048;
      3'h2:    dbt_div = 18'd4096;
      3'h3:    dbt_div = 18'd8192;
      3'h4:    dbt_div = 18'd16384;
      3'h5:    dbt_div = 18'd32768;
      3'h6:    dbt_div = 18'd64536;
      default: dbt_div = 18'd131072;
    endcase
  end

  always_comb begin
    tot_div = 18'd256 << tot_code;
  end

  // Second listing of code 000 as divide by 16 is ignored: 000 toggles the output every cycle
  always_comb begin
    case (opc_code)
      3'h0:    opc_div = 4'd1;
      3'h1:    opc_div = 4'd2;
      3'h2:    opc_div = 4'd3;
      3'h3:    opc_div = 4'd4;
      3'h4:    opc_div = 4'd6;
      3'h5:    opc_div = 4'd8;
      3'h6:    opc_div = 4'd12;
      default: opc_div = 4'd15;
    endcase
  end

  cdm_tick_div u_debounce (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .ref_tick (ref_tick),
    .divisor  (dbt_div),
    .tick     (debounce_tick)
  );

  cdm_tick_div u_timeout (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .ref_tick (ref_tick),
    .divisor  (tot_div),
    .tick     (timeout_tick)
  );

  // Divide by N: high for first half of N cycles. Code 111 count wraps at 16.
  always_comb begin
    next_opc_cnt = opc_cnt + 4'h1;
    if (opc_code != 3'h7 && opc_cnt >= opc_div - 4'h1) begin
      next_opc_cnt = 4'h0;
    end
    if (opc_code == 3'h0) begin
      next_gpio_output_clock = ~gpio_output_clock;
    end else if (opc_code == 3'h7) begin
      next_gpio_output_clock = next_opc_cnt < 4'd8;
    end else begin
      next_gpio_output_clock = next_opc_cnt < (opc_div >> 1);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      opc_cnt           <= 4'h0;
      gpio_output_clock <= 1'b0;
    end else begin
      opc_cnt           <= next_opc_cnt;
      gpio_output_clock <= next_gpio_output_clock;
    end
  end

  // Mixer controls
  assign left_boost_mixer_mute  = input_mixer_mute_enable[LEFT_MUTE_BIT];
  assign right_boost_mixer_mute = input_mixer_mute_enable[RIGHT_MUTE_BIT];
  assign left_boost_mixer_on  = input_mixer_mute_enable[LEFT_ENA_BIT]
                              | left_input_path_enable;
  assign right_boost_mixer_on = input_mixer_mute_enable[RIGHT_ENA_BIT]
                              | right_input_path_enable;
  assign left_input_amp_on  = left_input_path_enable;
  assign right_input_amp_on = right_input_path_enable;

  assign left_second_input_gain  = left_mixer_gains[SECOND_LSB +: 3];
  assign left_third_input_gain   = left_mixer_gains[THIRD_LSB +: 3];
  assign left_pga_to_mixer_gain  = left_mixer_gains[PGA_LSB +: 3];
  assign right_second_input_gain = right_mixer_gains[SECOND_LSB +: 3];
  assign right_third_input_gain  = right_mixer_gains[THIRD_LSB +: 3];
  assign right_pga_to_mixer_gain = right_mixer_gains[PGA_LSB +: 3];

  // Order per side: second input, third input, PGA
  assign left_source_connect  = mixer_source_select[5:3];
  assign right_source_connect = mixer_source_select[2:0];

  assign boost_mixer_bias_scale = input_bias_scaling[MIX_BIAS_LSB +: 3];
  assign input_amp_bias_scale   = input_bias_scaling[AMP_BIAS_LSB +: 3];
  // Reserved codes are stored, but flagged so analogue side can hold last safe bias
  assign bias_code_reserved = (boost_mixer_bias_scale != BIAS_X2_0
                               && boost_mixer_bias_scale != BIAS_X1_0
                               && boost_mixer_bias_scale != BIAS_X0_67)
                            || (input_amp_bias_scale != BIAS_X2_0
                               && input_amp_bias_scale != BIAS_X0_67);
endmodule : cdm_regs

/* verilog/cdm_tick_div.sv */
`timescale 1ns/10ps
module cdm_tick_div (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ref_tick,
  input  wire logic [17:0] divisor,
  output logic             tick
);
  logic [17:0] cnt;
  logic [17:0] next_cnt;
  logic        next_tick;

  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (ref_tick) begin
      if (cnt >= divisor - 18'h1) begin
        next_cnt  = 18'h0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 18'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt  <= 18'h0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : cdm_tick_div
